// >>> verilog/usb_addr_state_regs.vh
// Offsets, field positions and reset values of the address and state register
`ifndef USB_ADDR_STATE_REGS_VH
`define USB_ADDR_STATE_REGS_VH

// ****************************************************************
// Register offset
// ****************************************************************
`define ADDRESS_AND_STATE_OFS 12'h0200

// ****************************************************************
// Field positions
// ****************************************************************
`define FLD_STAGE_ERR       15
`define FLD_TWO_WAY         14
`define FLD_SPEED_HI        13
`define FLD_SPEED_LO        12
`define FLD_SUSPEND         11
`define FLD_CONFIGURED      10
`define FLD_ADDRESSED       9
`define FLD_DEFAULT         8
`define FLD_ADDR_HI         6
`define FLD_ADDR_LO         0

// ****************************************************************
// Codes and reset values
// ****************************************************************
`define SPEED_FULL          2'b01
`define STATE_DEFAULT       3'b001
`define ADDR_RESET          7'h00
`define FAULT_RESET         1'b0
`define TWO_WAY_RESET       1'b0
`define SUSPEND_RESET       1'b0

`endif

// >>> verilog/usb_device_address_state.v
// Device address and device state register of a full-speed USB function
//
// Functional notes
// - Setup in data/status or STALL sets fault
// - Normal status stage completion clears fault
// - Select bit lets endpoint carry both directions
// - Speed field reads 01, read only
// - Suspend bit reflects function core suspend
// - Bus reset forces default state 001
// - System or bus reset restores reset values
`timescale 1ns/1ps
`default_nettype none
`include "usb_addr_state_regs.vh"

module usb_device_address_state #(
  parameter ADDR_W = 12
) (
  input  wire              clk,
  input  wire              arst_n,
  input  wire              usb_bus_reset,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [31:0]       reg_wdata,
  output reg  [31:0]       reg_rdata,
  output reg               reg_rvalid,
  input  wire              setup_in_data_status,
  input  wire              stall_sent,
  input  wire              ctrl_status_ok,
  input  wire              core_suspended,
  output reg               endpoint_two_way_select,
  output reg  [6:0]        dev_address,
  output reg  [2:0]        dev_state
);

  // ****************************************************************
  // Local state
  // ****************************************************************
  reg         fault_r;
  reg         fault_nxt;
  reg         suspend_r;
  reg         suspend_nxt;
  reg         two_way_nxt;
  reg  [2:0]  state_nxt;
  reg  [6:0]  address_nxt;
  reg  [31:0] rdata_nxt;
  reg         rvalid_nxt;
  wire        wr_hit;
  wire        rd_hit;
  wire [31:0] word;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Shared by write and read decode
  function addr_hit;
    input [ADDR_W-1:0] addr;
    begin
      addr_hit = (addr == `ADDRESS_AND_STATE_OFS);
    end
  endfunction

  // Fixed layout of the readback word
  function [31:0] pack_word;
    input       fault;
    input       two_way;
    input       suspend;
    input [2:0] state;
    input [6:0] address;
    begin
      pack_word = {16'h0000,
                   fault,
                   two_way,
                   `SPEED_FULL,
                   suspend,
                   state,
                   1'b0,
                   address};
    end
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign wr_hit = reg_wr & addr_hit(reg_addr);
  assign rd_hit = reg_rd & addr_hit(reg_addr);

  // Readback of writable fields plus live status
  assign word = pack_word(fault_r,
                          endpoint_two_way_select,
                          suspend_r,
                          dev_state,
                          dev_address);

  // ****************************************************************
  // Fault flag
  // ****************************************************************
  always @* begin
    fault_nxt = fault_r;
    if (wr_hit) begin
      fault_nxt = reg_wdata[`FLD_STAGE_ERR];
    end
    if (ctrl_status_ok) begin
      fault_nxt = 1'b0;
    end
    if (setup_in_data_status | stall_sent) begin
      fault_nxt = 1'b1;
    end
    if (usb_bus_reset) begin
      fault_nxt = `FAULT_RESET;
    end
  end

  // ****************************************************************
  // Two way select
  // ****************************************************************
  always @* begin
    two_way_nxt = endpoint_two_way_select;
    if (wr_hit) begin
      two_way_nxt = reg_wdata[`FLD_TWO_WAY];
    end
    if (usb_bus_reset) begin
      two_way_nxt = `TWO_WAY_RESET;
    end
  end

  // ****************************************************************
  // Device state
  // ****************************************************************
  always @* begin
    state_nxt = dev_state;
    // only writable fields taken
    // Not checked for one-hot; firmware owns the encoding
    if (wr_hit) begin
      state_nxt = reg_wdata[`FLD_CONFIGURED:`FLD_DEFAULT];
    end
    if (usb_bus_reset) begin
      state_nxt = `STATE_DEFAULT;
    end
  end

  // ****************************************************************
  // Device address
  // ****************************************************************
  always @* begin
    address_nxt = dev_address;
    if (wr_hit) begin
      address_nxt = reg_wdata[`FLD_ADDR_HI:`FLD_ADDR_LO];
    end
    if (usb_bus_reset) begin
      address_nxt = `ADDR_RESET;
    end
  end

  // ****************************************************************
  // Suspend status
  // ****************************************************************
  // One cycle late; status only, no timing depends on it
  always @* begin
    suspend_nxt = core_suspended;
    if (usb_bus_reset) begin
      suspend_nxt = `SUSPEND_RESET;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // speed constant full speed
  always @* begin
    rvalid_nxt = reg_rd;
    // Unmapped addresses read zero
    rdata_nxt  = 32'h0000_0000;
    if (rd_hit) begin
      rdata_nxt = word;
    end
  end

  // ****************************************************************
  // Flip-flops
  // ****************************************************************
  // Bus reset lives in next state so async branches stay constant
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_r <= `FAULT_RESET;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      endpoint_two_way_select <= `TWO_WAY_RESET;
    end else begin
      endpoint_two_way_select <= two_way_nxt;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_state <= `STATE_DEFAULT;
    end else begin
      dev_state <= state_nxt;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_address <= `ADDR_RESET;
    end else begin
      dev_address <= address_nxt;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      suspend_r <= `SUSPEND_RESET;
    end else begin
      suspend_r <= suspend_nxt;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= rdata_nxt;
      reg_rvalid <= rvalid_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> bench/usb_addr_state_asserts.sv
// Checker for the address and state register
`timescale 1ns/1ps
`default_nettype none
module usb_addr_state_chk (
  input wire logic clk, arst_n, usb_bus_reset, reg_wr, reg_rd, reg_rvalid,
  input wire logic setup_in_data_status, stall_sent, ctrl_status_ok,
  input wire logic core_suspended, endpoint_two_way_select,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata,
  input wire logic [6:0] dev_address,
  input wire logic [2:0] dev_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_set;
    (setup_in_data_status || stall_sent) && !usb_bus_reset
      ##1 !(ctrl_status_ok || reg_wr || usb_bus_reset)
      ##1 (reg_rd && reg_addr == 12'h200);
  endsequence
  sequence s_clr;
    ctrl_status_ok && !setup_in_data_status && !stall_sent
      ##1 !(setup_in_data_status || stall_sent || reg_wr)
      ##1 (reg_rd && reg_addr == 12'h200);
  endsequence
  a_fault_set: assert property (s_set |=> reg_rdata[15])
    else $error("fault bit not set");
  a_fault_clear: assert property (s_clr |=> !reg_rdata[15])
    else $error("fault bit not cleared");
  a_field_write: assert property (
    reg_wr && reg_addr == 12'h200 && !usb_bus_reset |=>
    endpoint_two_way_select == $past(reg_wdata[14]) &&
    dev_address == $past(reg_wdata[6:0])) else $error("write lost");
  a_speed_code: assert property (
    reg_rvalid && $past(reg_addr) == 12'h200
    |-> reg_rdata[13:12] == 2'h1) else $error("bad speed");
  a_suspend_seen: assert property (
    reg_rvalid && $past(reg_addr) == 12'h200 && !$past(usb_bus_reset, 2)
    && $past(core_suspended, 2) && $past(core_suspended, 3)
    |-> reg_rdata[11]) else $error("suspend not shown");
  a_bus_reset: assert property (usb_bus_reset |=>
    dev_state == 3'h1 && dev_address == 7'h00 && !endpoint_two_way_select)
    else $error("bus reset state wrong");
  a_reset_vals: assert property ($rose(arst_n) |->
    dev_state == 3'h1 && dev_address == 7'h00) else $error("reset wrong");
  a_ro_zero: assert property (
    reg_rvalid |-> !reg_rdata[7] && reg_rdata[31:16] == 16'h0000)
    else $error("reserved bits set");
endmodule
bind usb_device_address_state usb_addr_state_chk chk_u (.*);
`default_nettype wire

// >>> bench/usb_host_model.sv
// Host side event source for control transfer outcomes
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input  wire logic clk,
  output logic      usb_bus_reset, setup_in_data_status,
  output logic      stall_sent, ctrl_status_ok
);
  initial {usb_bus_reset, setup_in_data_status, stall_sent, ctrl_status_ok} = 0;
  // One cycle event pulse, host order kept by caller
  task ev(input logic [3:0] p);
    @(posedge clk) #1;
    {usb_bus_reset, setup_in_data_status, stall_sent, ctrl_status_ok} = p;
    @(posedge clk) #1;
    {usb_bus_reset, setup_in_data_status, stall_sent, ctrl_status_ok} = 0;
  endtask
endmodule
`default_nettype wire

// >>> bench/usb_device_address_state_tb.sv
// Testbench for the address and state register
`timescale 1ns/1ps
`default_nettype none
module usb_device_address_state_tb;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, core_suspended = 0;
  logic [11:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic reg_rvalid, endpoint_two_way_select, usb_bus_reset;
  logic setup_in_data_status, stall_sent, ctrl_status_ok;
  logic [6:0] dev_address;
  logic [2:0] dev_state;
  int err_count = 0, samples_checked = 0;
  usb_device_address_state dut_u (.*);
  usb_host_model host_u (.*);
  always #12.5 clk = ~clk;
  task final_report;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t %h %h", $time, got, exp);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk) #1;
    reg_rd = 1;
    reg_addr = a;
    @(posedge clk) #1;
    reg_rd = 0;
    chk({31'h0000_0000, reg_rvalid}, 32'h0000_0001);
    chk(reg_rdata, e);
  endtask
  task wr(input logic [31:0] d);
    @(posedge clk) #1;
    reg_wr = 1;
    reg_addr = 12'h200;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 0;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 arst_n = 1;
    rd(12'h200, 32'h0000_1100);
    wr(32'hFFFF_F285);
    rd(12'h200, 32'h0000_D205);
    host_u.ev(4'h1);
    rd(12'h200, 32'h0000_5205);
    host_u.ev(4'h4);
    rd(12'h200, 32'h0000_D205);
    host_u.ev(4'h1);
    host_u.ev(4'h2);
    rd(12'h200, 32'h0000_D205);
    core_suspended = 1;
    repeat (2) @(posedge clk);
    rd(12'h200, 32'h0000_DA05);
    core_suspended = 0;
    repeat (2) @(posedge clk);
    host_u.ev(4'h8);
    rd(12'h200, 32'h0000_1100);
    rd(12'h204, 32'h0000_0000);
    host_u.ev(4'h1);
    wr(32'h0000_0223);
    rd(12'h200, 32'h0000_1223);
    wr(32'h0000_0423);
    rd(12'h200, 32'h0000_1423);
    wr(32'h0000_0223);
    rd(12'h200, 32'h0000_1223);
    wr(32'h0000_0100);
    rd(12'h200, 32'h0000_1100);
    final_report;
  end
  initial begin
    #100us err_count++;
    final_report;
  end
endmodule
`default_nettype wire
